// ---- lsrb_pkg.sv ----
// package of constants for the loop status register bank
package lsrb_pkg;
  localparam logic [7:0] LSRB_OFS_LOOP_FAULT = 8'h04;
  localparam logic [7:0] LSRB_OFS_ADDR_FAULT = 8'h05;
  localparam logic [7:0] LSRB_OFS_PROGRESS = 8'h06;
  localparam logic [7:0] LSRB_OFS_COUNT = 8'h07;
  localparam logic [7:0] LSRB_OFS_MAP_FIRST = 8'h08;
  localparam logic [7:0] LSRB_OFS_MAP_LAST = 8'h7f;
  localparam logic [7:0] LSRB_OFS_FAIL_FIRST = 8'h80;
  localparam logic [7:0] LSRB_OFS_FAIL_LAST = 8'hf7;
  localparam logic [7:0] LSRB_OFS_SIDE_OK = 8'h00;
  localparam int LSRB_BIT_SIDE_A_OK = 14;
  localparam int LSRB_BIT_SIDE_B_OK = 15;
  localparam int LSRB_BIT_FLT_PORT = 15;
  localparam int LSRB_BIT_DUP = 14;
  localparam int LSRB_BIT_HIGH = 13;
  localparam int LSRB_BIT_ZERO = 12;
  localparam logic [3:0] LSRB_FLT_OPEN = 4'h5;
  localparam logic [3:0] LSRB_FLT_SHORT = 4'h6;
  localparam logic [7:0] LSRB_RSN_RESET = 8'h01;
  localparam logic [7:0] LSRB_RSN_CMD = 8'h09;
  localparam logic [7:0] LSRB_RSN_MAX = 8'h09;
  localparam logic [7:0] LSRB_STEP_MAX = 8'h09;
  localparam logic [7:0] LSRB_FC_COILS = 8'h01;
  localparam logic [7:0] LSRB_FC_HOLD = 8'h03;
  localparam logic [7:0] LSRB_FC_INPUT = 8'h04;
  localparam logic [7:0] LSRB_RECONF_LOC = 8'h03;
  localparam int LSRB_UNITS = 240;
endpackage : lsrb_pkg

// ---- lsrb_bank.sv ----
// loop status register bank: status, unit map and failure counters
`timescale 1ns/1ps
// Operation
// RL1 - faulty loop interface module makes side unhealthy
// RL2 - unreachable side B reads as unhealthy
// RL3 - fault bit 15 names port A/B
// RL4 - bits 14,13,12 flag duplicate, high, zero
// RL5 - bits 11-8 fault type 5/6
// RL6 - low byte reason codes 1 to 4
// RL7 - reason codes 5 to 9
// RL8 - address fault: position high, address low
// RL9 - progress steps 1 to 5
// RL10 - progress steps 6 to 9
// RL11 - unit counts: port B high, A low
// RL12 - 240-entry unit map at 8..127
// RL13 - map register packs earlier unit high
// RL14 - per-unit failure counter counts each failure
// RL15 - failure register packs lower unit high
// RL16 - map and counters read with 03/04 only
// RL17 - status registers also readable with 01
// RL18 - locations are zero based
// RL19 - non-zero write to location 3 reconfigures
// RL20 - unused codes zero, writes ignored
module lsrb_bank
  import lsrb_pkg::*;
#(
  parameter int UNITS = LSRB_UNITS
) (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [1:0] lim_fault_a_i, // faulty interface modules, side A
  input wire logic [1:0] lim_fault_b_i, // faulty interface modules, side B
  input wire logic side_b_reach_i, // side B answering
  input wire logic flt_upd_i, // loop fault update strobe
  input wire logic flt_port_i, // 0 port A, 1 port B
  input wire logic flt_dup_i, // duplicate address seen
  input wire logic flt_high_i, // address too high seen
  input wire logic flt_zero_i, // zero address seen
  input wire logic [3:0] flt_type_i, // loop fault type
  input wire logic [7:0] flt_reason_i, // reason for configuration
  input wire logic [7:0] flt_pos_i, // loop position of fault
  input wire logic [7:0] flt_addr_i, // offending address
  input wire logic prog_upd_i, // progress step strobe
  input wire logic [7:0] prog_step_i, // progress step code
  input wire logic cnt_upd_i, // unit count strobe
  input wire logic [7:0] cnt_a_i, // units on port A
  input wire logic [7:0] cnt_b_i, // units on port B
  input wire logic map_we_i, // unit map write strobe
  input wire logic [7:0] map_idx_i, // map entry, connection order
  input wire logic [7:0] map_addr_i, // unit address for entry
  input wire logic fail_i, // comms failure pulse
  input wire logic [7:0] fail_unit_i, // failing unit, 1-based
  input wire logic rd_i, // host read request
  input wire logic [7:0] rd_fc_i, // host function code
  input wire logic [7:0] rd_loc_i, // zero-based register location
  input wire logic wr_i, // host write request
  input wire logic [7:0] wr_loc_i, // zero-based write location
  input wire logic [15:0] wr_data_i, // host write data
  output logic rd_valid_o, // read answer valid, one cycle
  output logic rd_err_o, // read refused, one cycle
  output logic [15:0] rd_data_o, // read data
  output logic reconf_o // reconfigure request pulse
);

  // status registers as the host sees them
  logic [15:0] loop_fault_info;
  logic [15:0] address_fault_detail;
  logic [15:0] loop_config_progress;
  logic [15:0] units_found_count;
  logic [15:0] side_ok;
  // per-unit stores and their host word pairs
  logic [7:0] unit_address_map [UNITS];
  logic [7:0] unit_failure_counts [UNITS];
  logic [15:0] map_word [UNITS / 2];
  logic [15:0] fail_word [UNITS / 2];
  // reconfigure command tracking
  logic reconf_hit;
  logic reconf_seen;
  // filtered next values for the code fields
  logic [3:0] next_type;
  logic [7:0] next_reason;
  logic [7:0] next_step;
  // read decode
  logic [6:0] widx;
  logic is_stat;
  logic is_map;
  logic is_fail;
  logic fc_reg;
  logic fc_coil;
  logic fc_ok;
  logic rd_ok;
  logic [15:0] stat_word;
  logic [15:0] next_rd_data;

  // side health, sampled each cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      side_ok <= 16'h0000;
    end else begin
      side_ok <= 16'h0000; // RL20
      side_ok[LSRB_BIT_SIDE_A_OK] <= ~|lim_fault_a_i; // RL1
      side_ok[LSRB_BIT_SIDE_B_OK] <= ~|lim_fault_b_i & side_b_reach_i; // RL1 RL2
    end
  end

  // fault type: open or short circuit, other codes read as zero
  always_comb begin
    next_type = 4'h0;
    case (flt_type_i)
      LSRB_FLT_OPEN: next_type = LSRB_FLT_OPEN; // RL5
      LSRB_FLT_SHORT: next_type = LSRB_FLT_SHORT; // RL5
      default: next_type = 4'h0; // RL20
    endcase
  end

  // reason for the last configuration; a host command overrides
  always_comb begin
    next_reason = 8'h00;
    case (flt_reason_i)
      8'h01: next_reason = flt_reason_i; // RL6
      8'h02: next_reason = flt_reason_i; // RL6
      8'h03: next_reason = flt_reason_i; // RL6
      8'h04: next_reason = flt_reason_i; // RL6
      8'h05: next_reason = flt_reason_i; // RL7
      8'h06: next_reason = flt_reason_i; // RL7
      8'h07: next_reason = flt_reason_i; // RL7
      8'h08: next_reason = flt_reason_i; // RL7
      8'h09: next_reason = flt_reason_i; // RL7
      default: next_reason = 8'h00; // RL20
    endcase
    if (reconf_seen) begin
      next_reason = LSRB_RSN_CMD; // RL7 RL19
    end
  end

  // configuration progress steps; other codes read as zero
  always_comb begin
    next_step = 8'h00;
    case (prog_step_i)
      8'h01: next_step = prog_step_i; // RL9
      8'h02: next_step = prog_step_i; // RL9
      8'h03: next_step = prog_step_i; // RL9
      8'h04: next_step = prog_step_i; // RL9
      8'h05: next_step = prog_step_i; // RL9
      8'h06: next_step = prog_step_i; // RL10
      8'h07: next_step = prog_step_i; // RL10
      8'h08: next_step = prog_step_i; // RL10
      8'h09: next_step = prog_step_i; // RL10
      default: next_step = 8'h00; // RL20
    endcase
  end

  // loop fault register: address faults, fault type and reason
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_fault_info <= {8'h00, LSRB_RSN_RESET}; // RL6
    end else if (flt_upd_i) begin
      loop_fault_info[LSRB_BIT_FLT_PORT] <= flt_port_i; // RL3
      loop_fault_info[LSRB_BIT_DUP] <= flt_dup_i; // RL4
      loop_fault_info[LSRB_BIT_HIGH] <= flt_high_i; // RL4
      loop_fault_info[LSRB_BIT_ZERO] <= flt_zero_i; // RL4
      loop_fault_info[11:8] <= next_type; // RL5
      loop_fault_info[7:0] <= next_reason; // RL6
    end else if (reconf_seen) begin
      loop_fault_info[7:0] <= LSRB_RSN_CMD; // RL19
    end
  end

  // address fault detail: loop position high, address low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      address_fault_detail <= 16'h0000;
    end else if (flt_upd_i) begin
      address_fault_detail <= {flt_pos_i, flt_addr_i}; // RL8
    end
  end

  // only a non-zero write to the reconfigure location acts
  assign reconf_hit = wr_i && wr_loc_i == LSRB_RECONF_LOC && wr_data_i != 16'h0000; // RL19 RL20

  // reconfigure command, one cycle after the write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reconf_seen <= 1'b0;
    end else begin
      reconf_seen <= reconf_hit; // RL19
    end
  end

  // reconfigure request straight from its flop
  assign reconf_o = reconf_seen;

  // configuration progress
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_config_progress <= 16'h0000;
    end else if (prog_upd_i) begin
      loop_config_progress <= {8'h00, next_step}; // RL9 RL10
    end
  end

  // unit counts: port B high, port A low
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      units_found_count <= 16'h0000;
    end else if (cnt_upd_i) begin
      units_found_count <= {cnt_b_i, cnt_a_i}; // RL11
    end
  end

  // per-entry map store, failure counter and word pairing
  for (genvar g = 0; g < UNITS; g++) begin : g_unit
    // map entry g, written in connection order
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        unit_address_map[g] <= 8'h00;
      end else if (map_we_i && map_idx_i == 8'(g)) begin
        unit_address_map[g] <= map_addr_i; // RL12
      end
    end

    // failure counter for unit g + 1, wraps past 255
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        unit_failure_counts[g] <= 8'h00;
      end else if (fail_i && fail_unit_i == 8'(g + 1)) begin
        unit_failure_counts[g] <= unit_failure_counts[g] + 8'h01; // RL14
      end
    end

    // even entries pair with the next one, earlier entry high
    if (g % 2 == 0) begin : g_pair
      assign map_word[g / 2] = {unit_address_map[g], unit_address_map[g + 1]}; // RL13
      assign fail_word[g / 2] = {unit_failure_counts[g], unit_failure_counts[g + 1]}; // RL15
    end
  end

  // location decode, zero-based; word index stays in range
  always_comb begin
    is_stat = rd_loc_i >= LSRB_OFS_LOOP_FAULT && rd_loc_i <= LSRB_OFS_COUNT; // RL18
    is_stat = is_stat || rd_loc_i == LSRB_OFS_SIDE_OK;
    is_map = rd_loc_i >= LSRB_OFS_MAP_FIRST && rd_loc_i <= LSRB_OFS_MAP_LAST; // RL12
    is_fail = rd_loc_i >= LSRB_OFS_FAIL_FIRST && rd_loc_i <= LSRB_OFS_FAIL_LAST;
    fc_reg = rd_fc_i == LSRB_FC_HOLD || rd_fc_i == LSRB_FC_INPUT; // RL16
    fc_coil = rd_fc_i == LSRB_FC_COILS; // RL17
    fc_ok = 1'b0;
    if (is_stat) begin
      fc_ok = fc_reg || fc_coil; // RL17
    end else if (is_map || is_fail) begin
      fc_ok = fc_reg; // RL16
    end
    widx = 7'h00;
    if (is_map) begin
      widx = 7'(rd_loc_i - LSRB_OFS_MAP_FIRST);
    end else if (is_fail) begin
      widx = 7'(rd_loc_i - LSRB_OFS_FAIL_FIRST);
    end
  end

  // accepted read: known location with a suitable function code
  assign rd_ok = rd_i && fc_ok;

  // status word for the addressed status location
  always_comb begin
    stat_word = side_ok;
    unique case (rd_loc_i)
      LSRB_OFS_LOOP_FAULT: stat_word = loop_fault_info;
      LSRB_OFS_ADDR_FAULT: stat_word = address_fault_detail;
      LSRB_OFS_PROGRESS: stat_word = loop_config_progress;
      LSRB_OFS_COUNT: stat_word = units_found_count;
      default: stat_word = side_ok; // RL20
    endcase
  end

  // next read data by location range
  always_comb begin
    next_rd_data = stat_word;
    if (is_map) begin
      next_rd_data = map_word[widx]; // RL13
    end else if (is_fail) begin
      next_rd_data = fail_word[widx]; // RL15
    end
  end

  // one-cycle answer strobes; only a reconfigure write alters status (reason code)
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_o <= 1'b0;
      rd_err_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_ok;
      rd_err_o <= rd_i && !fc_ok; // RL16
    end
  end

  // read data, held until the next accepted read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
    end else if (rd_ok) begin
      rd_data_o <= next_rd_data;
    end
  end

endmodule : lsrb_bank

// ---- lsrb_bank_monitor.sv ----
// assertion checker for the loop status register bank
`timescale 1ns/1ps
module lsrb_bank_monitor (
  input wire logic clk_sys_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic [1:0] lim_fault_b_i, // side b faults
  input wire logic side_b_reach_i, // side b answers
  input wire logic rd_i, // read
  input wire logic [7:0] rd_fc_i, // function code
  input wire logic [7:0] rd_loc_i, // location
  input wire logic wr_i, // write
  input wire logic [7:0] wr_loc_i, // write location
  input wire logic [15:0] wr_data_i, // write data
  input wire logic rd_valid_o, // answer
  input wire logic rd_err_o, // refusal
  input wire logic [15:0] rd_data_o, // data
  input wire logic reconf_o // reconfigure
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // a reconfigure command, and a holding-register read
  sequence s_kick;
    wr_i && wr_loc_i == 8'h03 && wr_data_i != 16'h0000;
  endsequence
  sequence s_rd(logic [7:0] l);
    rd_i && rd_fc_i == 8'h03 && rd_loc_i == l;
  endsequence
  a_kick_pulse:
    assert property (s_kick |=> reconf_o) else $error("reconfigure pulse missing");
  a_write_ignored:
    assert property (!(wr_i && wr_loc_i == 8'h03 && wr_data_i != 16'h0000) |=> !reconf_o)
      else $error("write not ignored");
  a_side_b_health:
    assert property (s_rd(8'h00) |=> rd_data_o[15] == $past(side_b_reach_i &&
      lim_fault_b_i == 2'h0)) else $error("side b health wrong");
  a_map_refused:
    assert property (rd_i && rd_fc_i == 8'h01 && rd_loc_i >= 8'h08 |=> rd_err_o)
      else $error("coil read of map not refused");
  a_status_coils:
    assert property (rd_i && rd_fc_i == 8'h01 && rd_loc_i inside {[8'h04:8'h07]}
      |=> rd_valid_o && !rd_err_o) else $error("coil read of status refused");
  a_fault_type:
    assert property (s_rd(8'h04) |=> rd_data_o[11:8] inside {4'h0, 4'h5, 4'h6})
      else $error("bad fault type");
  a_step_range:
    assert property (s_rd(8'h06) |=> rd_data_o <= 16'h0009) else $error("bad step");
  a_answer_once:
    assert property (rd_i |=> rd_valid_o != rd_err_o) else $error("answer not single");
  a_quiet_idle:
    assert property (!rd_i |=> !rd_valid_o && !rd_err_o) else $error("spurious answer");
endmodule : lsrb_bank_monitor

// ---- lsrb_host.sv ----
// host model issuing register reads and writes
`timescale 1ns/1ps
module lsrb_host (
  input wire logic clk_sys_i, // clock
  input wire logic rd_err_o, // refusal
  input wire logic [15:0] rd_data_o, // read data
  input wire logic reconf_o, // reconfigure
  output logic rd_i, // read
  output logic [7:0] rd_fc_i, // function code
  output logic [7:0] rd_loc_i, // location
  output logic wr_i, // write
  output logic [7:0] wr_loc_i, // write location
  output logic [15:0] wr_data_i // write data
);
  initial {rd_i, rd_fc_i, rd_loc_i, wr_i, wr_loc_i, wr_data_i} = '0;
  // one read; answer lands one cycle after it is taken
  task automatic rd(input logic [7:0] fc, loc, output logic [15:0] d, output logic e);
    @(posedge clk_sys_i);
    {rd_i, rd_fc_i} <= {1'b1, fc};
    rd_loc_i <= loc;
    @(posedge clk_sys_i);
    {rd_i, rd_loc_i} <= {1'b0, ~loc};
    #1 {d, e} = {rd_data_o, rd_err_o};
  endtask : rd
  // one write; reconfigure pulse sampled a cycle on
  task automatic wr(input logic [7:0] loc, input logic [15:0] dat, output logic k);
    @(posedge clk_sys_i);
    {wr_i, wr_loc_i, wr_data_i} <= {1'b1, loc, dat};
    @(posedge clk_sys_i);
    {wr_i, wr_data_i} <= {1'b0, ~dat};
    #1 k = reconf_o;
  endtask : wr
endmodule : lsrb_host

// ---- lsrb_bank_tb_top.sv ----
// testbench for the loop status register bank
`timescale 1ns/1ps
module lsrb_bank_tb_top;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, side_b_reach_i = 1'b1, flt_upd_i = 1'b0, e, k;
  logic flt_port_i = 1'b0, flt_dup_i = 1'b0, flt_high_i = 1'b0, flt_zero_i = 1'b0;
  logic prog_upd_i = 1'b0, cnt_upd_i = 1'b0, map_we_i = 1'b0, fail_i = 1'b0;
  logic [1:0] lim_fault_a_i = 2'h0, lim_fault_b_i = 2'h0;
  logic [3:0] flt_type_i = 4'h0;
  logic [7:0] flt_reason_i = 8'h0, flt_pos_i = 8'h0, flt_addr_i = 8'h0, prog_step_i = 8'h0;
  logic [7:0] cnt_a_i = 8'h0, cnt_b_i = 8'h0, map_idx_i = 8'h0, map_addr_i = 8'h0;
  logic [7:0] fail_unit_i = 8'h0, rd_fc_i, rd_loc_i, wr_loc_i;
  logic rd_i, wr_i, rd_valid_o, rd_err_o, reconf_o;
  logic [15:0] wr_data_i, rd_data_o, d;
  int err_count = 0, num_checks = 0;
  // rows: function code, location, refused, data
  logic [35:0] rows [12] = '{36'h010400001, 36'h030500000, 36'h040600000, 36'h010700000,
    36'h030800000, 36'h048000000, 36'h04000c000, 36'h010810000, 36'h018010000,
    36'h050410000, 36'h020410000, 36'h03f810000};
  logic [23:0] after [7] = '{24'h04d607, 24'h052a00, 24'h060009, 24'h070503,
    24'h081122, 24'h7f0033, 24'h800201};
  lsrb_bank lsrb_bank_i (.clk_sys_i, .rst_n_i, .lim_fault_a_i, .lim_fault_b_i,
    .side_b_reach_i, .flt_upd_i, .flt_port_i, .flt_dup_i, .flt_high_i, .flt_zero_i,
    .flt_type_i, .flt_reason_i, .flt_pos_i, .flt_addr_i, .prog_upd_i, .prog_step_i,
    .cnt_upd_i, .cnt_a_i, .cnt_b_i, .map_we_i, .map_idx_i, .map_addr_i, .fail_i,
    .fail_unit_i, .rd_i, .rd_fc_i, .rd_loc_i, .wr_i, .wr_loc_i, .wr_data_i, .rd_valid_o,
    .rd_err_o, .rd_data_o, .reconf_o);
  lsrb_host lsrb_host_i (.clk_sys_i, .rd_err_o, .rd_data_o, .reconf_o, .rd_i, .rd_fc_i,
    .rd_loc_i, .wr_i, .wr_loc_i, .wr_data_i);
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(input logic got, input logic exp);
    chk_data({15'h0, got}, {15'h0, exp});
  endtask : chk_flag
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  always #4 clk_sys_i = ~clk_sys_i;
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    foreach (rows[i]) begin
      lsrb_host_i.rd(rows[i][35:28], rows[i][27:20], d, e);
      chk_flag(e, rows[i][16]);
      if (!rows[i][16]) chk_data(d, rows[i][15:0]);
    end
    $display("table test done");
    // load fault, step, counts, map entries and failures
    @(posedge clk_sys_i);
    {flt_upd_i, prog_upd_i, cnt_upd_i, map_we_i, fail_i} <= 5'h1f;
    {flt_port_i, flt_dup_i, flt_high_i, flt_zero_i} <= 4'hd;
    {flt_type_i, flt_reason_i, flt_pos_i, flt_addr_i} <= 28'h6072a00;
    {prog_step_i, cnt_b_i, cnt_a_i} <= 24'h090503;
    {map_idx_i, map_addr_i, fail_unit_i} <= 24'h001101;
    @(posedge clk_sys_i);
    {flt_upd_i, prog_upd_i, cnt_upd_i, map_idx_i, map_addr_i} <= 19'h00122;
    @(posedge clk_sys_i);
    {map_idx_i, map_addr_i, fail_unit_i} <= 24'hef3302;
    @(posedge clk_sys_i);
    {map_we_i, fail_i} <= 2'h0;
    foreach (after[i]) begin
      lsrb_host_i.rd(8'h03, after[i][23:16], d, e);
      chk_data(d, after[i][15:0]);
    end
    $display("loaded test done");
    // side health: faulty module, then side b unreachable
    lim_fault_a_i <= 2'h1;
    lsrb_host_i.rd(8'h03, 8'h00, d, e);
    chk_data(d, 16'h8000);
    {lim_fault_a_i, side_b_reach_i} <= 3'h0;
    lsrb_host_i.rd(8'h04, 8'h00, d, e);
    chk_data(d, 16'h4000);
    $display("health test done");
    // writes: status and zero ignored, non-zero to 3 reconfigures
    lsrb_host_i.wr(8'h04, 16'hffff, k);
    chk_flag(k, 1'b0);
    lsrb_host_i.wr(8'h03, 16'h0000, k);
    chk_flag(k, 1'b0);
    lsrb_host_i.wr(8'h03, 16'h0100, k);
    chk_flag(k, 1'b1);
    lsrb_host_i.rd(8'h03, 8'h04, d, e);
    chk_data(d, 16'hd609);
    $display("write test done");
    // reset in mid-run: reason back to reset code, counters cleared
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    lsrb_host_i.rd(8'h03, 8'h04, d, e);
    chk_data(d, 16'h0001);
    lsrb_host_i.rd(8'h04, 8'h80, d, e);
    chk_data(d, 16'h0000);
    $display("reset test done");
    stop_test;
  end
endmodule : lsrb_bank_tb_top
bind lsrb_bank lsrb_bank_monitor lsrb_bank_monitor_i (.clk_sys_i, .rst_n_i, .lim_fault_b_i,
  .side_b_reach_i, .rd_i, .rd_fc_i, .rd_loc_i, .wr_i, .wr_loc_i, .wr_data_i, .rd_valid_o,
  .rd_err_o, .rd_data_o, .reconf_o);
